// ==== design/mgmt_access_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface mgmt_access_if;
    logic        rd;
    logic        wr;
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic [15:0] rdata;

    modport frame (output rd, output wr, output addr, output wdata, input rdata);
    modport regs  (input rd, input wr, input addr, input wdata, output rdata);
endinterface : mgmt_access_if
`default_nettype wire

// ==== design/mgmt_serial_port.sv ====
`timescale 1ns/100ps
`default_nettype none
module mgmt_serial_port #(
    parameter logic [4:0] PHY_ADDR = 5'h01
) (
    input  wire logic   clk_in,
    input  wire logic   nrst_in,
    input  wire logic   mdc_in,
    input  wire logic   mdio_in,
    output logic        mdio_out,
    output logic        mdio_oe_out,
    mgmt_access_if.frame acc
);
    import phy_mgmt_pkg::*;

    typedef struct packed {
        frame_state_t st;
        logic         mdc_q;
        logic [5:0]   cnt;
        logic [15:0]  sh;
        logic         is_rd;
        logic         is_wr;
        logic         rd;
        logic         wr;
        logic [4:0]   addr;
        logic [15:0]  wdata;
        logic         oe;
        logic         dout;
    } sp_state_t;

    sp_state_t   s;
    sp_state_t   next_s;
    logic        rise;
    logic        fall;
    logic [11:0] hdr;

    always_comb begin
        next_s       = s;
        next_s.mdc_q = mdc_in;
        next_s.rd    = 1'b0;
        next_s.wr    = 1'b0;
        rise = mdc_in & ~s.mdc_q;
        fall = ~mdc_in & s.mdc_q;
        hdr  = {s.sh[10:0], mdio_in};
        if (rise) begin
            unique case (s.st)
                FR_PRE: begin
                    if (mdio_in) begin
                        if (s.cnt != PREAMBLE_BITS) next_s.cnt = s.cnt + 6'h01;
                    end else begin
                        next_s.cnt = '0;
                        if (s.cnt == PREAMBLE_BITS) next_s.st = FR_START;
                    end
                end
                FR_START: begin
                    next_s.st = mdio_in ? FR_HDR : FR_PRE;
                end
                FR_HDR: begin
                    next_s.sh  = {s.sh[14:0], mdio_in};
                    next_s.cnt = s.cnt + 6'h01;
                    if (s.cnt == HDR_LAST) begin
                        next_s.cnt   = '0;
                        next_s.st    = FR_TA;
                        next_s.addr  = hdr[4:0];
                        next_s.is_rd = (hdr[11:10] == OP_READ) && (hdr[9:5] == PHY_ADDR);
                        next_s.is_wr = (hdr[11:10] == OP_WRITE) && (hdr[9:5] == PHY_ADDR);
                        next_s.rd    = next_s.is_rd;
                    end
                end
                FR_TA: begin
                    next_s.cnt = s.cnt + 6'h01;
                    if (s.cnt == TA_LAST) begin
                        next_s.cnt = '0;
                        next_s.st  = FR_DATA;
                        next_s.sh  = acc.rdata;
                    end
                end
                FR_DATA: begin
                    if (!s.is_rd) next_s.sh = {s.sh[14:0], mdio_in};
                    next_s.cnt = s.cnt + 6'h01;
                    if (s.cnt == DATA_LAST) begin
                        next_s.cnt   = '0;
                        next_s.st    = FR_PRE;
                        next_s.wr    = s.is_wr;
                        next_s.wdata = {s.sh[14:0], mdio_in};
                    end
                end
                default: begin
                    next_s.st  = FR_PRE;
                    next_s.cnt = '0;
                end
            endcase
        end else if (fall) begin
            // Drive only after the host has let go in turnaround
            if (s.st == FR_TA && s.cnt == TA_LAST && s.is_rd) begin
                next_s.oe   = 1'b1;
                next_s.dout = 1'b0;
            end else if (s.st == FR_DATA && s.is_rd) begin
                next_s.oe   = 1'b1;
                next_s.dout = s.sh[15];
                next_s.sh   = {s.sh[14:0], 1'b0};
            end else begin
                next_s.oe = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s <= '{st: FR_PRE, default: '0};
        end else begin
            s <= next_s;
        end
    end

    assign mdio_out    = s.dout;
    assign mdio_oe_out = s.oe;
    assign acc.rd      = s.rd;
    assign acc.wr      = s.wr;
    assign acc.addr    = s.addr;
    assign acc.wdata   = s.wdata;
endmodule : mgmt_serial_port
`default_nettype wire

// ==== design/phy_latch_bits.sv ====
`timescale 1ns/100ps
`default_nettype none
module phy_latch_bits #(
    parameter int N = 6
) (
    input  wire logic         clk_in,
    input  wire logic         nrst_in,
    input  wire logic [N-1:0] event_in,
    input  wire logic [N-1:0] clear_in,
    output logic      [N-1:0] bits_out
);
    typedef struct packed {
        logic [N-1:0] bits;
    } lh_state_t;

    lh_state_t s;
    lh_state_t next_s;

    // Set beats clear so an event during a read survives it
    always_comb begin
        next_s      = s;
        next_s.bits = (s.bits & ~clear_in) | event_in;
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign bits_out = s.bits;
endmodule : phy_latch_bits
`default_nettype wire

// ==== design/phy_mgmt_pkg.sv ====
package phy_mgmt_pkg;

    // ==========================================================
    // Register addresses on the management link
    localparam logic [4:0] REG_EXT_STATUS  = 5'h11;
    localparam logic [4:0] REG_TENBASE_OPS = 5'h12;

    // ==========================================================
    // Extended status field positions
    localparam int ST_PLL  = 9;
    localparam int ST_FC   = 8;
    localparam int ST_INV  = 7;
    localparam int ST_HALT = 6;
    localparam int ST_PEND = 5;
    localparam int ST_ANC  = 4;
    localparam int ST_SIG  = 3;
    localparam int ST_JAB  = 2;
    localparam int ST_RF   = 1;
    localparam int ST_LINK = 0;

    // ==========================================================
    // 10Base-T operations field positions and reset
    localparam int OPS_RJAB     = 15;
    localparam int OPS_POL      = 14;
    localparam int OPS_JAB_INH  = 5;
    localparam int OPS_APOL_INH = 3;
    localparam int OPS_SQE_INH  = 2;
    localparam int OPS_LINK_INH = 1;
    localparam int OPS_SQ_INH   = 0;
    localparam int OPS_CTRL_W   = 14;
    localparam logic [13:0] OPS_CTRL_RESET = 14'h0010;

    // ==========================================================
    // Latching-high bit slots
    localparam int LH_N    = 6;
    localparam int LH_PLL  = 0;
    localparam int LH_FC   = 1;
    localparam int LH_INV  = 2;
    localparam int LH_HALT = 3;
    localparam int LH_PEND = 4;
    localparam int LH_RJAB = 5;
    localparam logic [5:0] LH_STATUS_SET = 6'h1f;

    // ==========================================================
    // Serial frame layout
    localparam logic [5:0] PREAMBLE_BITS = 6'h20;
    localparam logic [5:0] HDR_LAST      = 6'h0b;
    localparam logic [5:0] TA_LAST       = 6'h01;
    localparam logic [5:0] DATA_LAST     = 6'h0f;
    localparam logic [1:0] OP_READ       = 2'h2;
    localparam logic [1:0] OP_WRITE      = 2'h1;

    // ==========================================================
    // Timing
    localparam int CLK_FREQ_HZ       = 20000000;
    localparam int RX_JABBER_TIME_US = 20000;
    localparam int RX_JABBER_CYCLES  = RX_JABBER_TIME_US * (CLK_FREQ_HZ / 1000000);

    typedef enum logic [2:0] {
        FR_PRE   = 3'h0,
        FR_START = 3'h1,
        FR_HDR   = 3'h3,
        FR_TA    = 3'h2,
        FR_DATA  = 3'h6
    } frame_state_t;

    typedef enum logic [1:0] {
        LINK_FAIL  = 2'h0,
        LINK_CHECK = 2'h1,
        LINK_PASS  = 2'h3
    } link10_state_t;

endpackage : phy_mgmt_pkg

// ==== design/phy_rx_status_and_tenbase_ops_regs.sv ====
`timescale 1ns/100ps
`default_nettype none
// Operation
// - PLL lock failure latches its status bit
// - False carrier latches its status bit
// - Invalid packet symbol raises RXER and latches
// - Halt symbol signalled to MAC and latched
// - Two idles inside packet latch premature end
// - Receive error flags undefined at 10 Mb/s
// - Latched flag shows event since read/reset
// - Negotiation complete only when enabled and done
// - Signal detect mirrors receive signal in 100TX
// - Jabber bit mirrors basic status jabber
// - Remote fault bit mirrors basic status
// - Link bit mirrors basic status link
// - Receive jabber latches receive jabber bit
// - Auto polarity inhibit stops polarity correction
// - SQE inhibit disables SQE test generation
// - Link loss inhibit forces link passed state
// - Polarity bit shows swapped receive pair
// - Jabber inhibit disables transmit jabber check
// - Squelch inhibit requires data then idle
// - SQE suppressed in full duplex, repeater
module phy_rx_status_and_tenbase_ops_regs #(
    parameter logic [4:0]  PHY_ADDR         = 5'h01,
    parameter int unsigned RX_JABBER_CYCLES = phy_mgmt_pkg::RX_JABBER_CYCLES
) (
    input  wire logic clk_in,
    input  wire logic nrst_in,
    input  wire logic mdc_in,
    input  wire logic mdio_in,
    output logic      mdio_out,
    output logic      mdio_oe_out,
    input  wire logic speed_100_in,
    input  wire logic full_duplex_in,
    input  wire logic repeater_mode_in,
    input  wire logic pll_lock_fail_in,
    input  wire logic false_carrier_in,
    input  wire logic rx_in_packet_in,
    input  wire logic rx_symbol_strobe_in,
    input  wire logic rx_symbol_invalid_in,
    input  wire logic rx_symbol_halt_in,
    input  wire logic rx_symbol_idle_in,
    input  wire logic an_enable_in,
    input  wire logic an_done_in,
    input  wire logic signal_detect_in,
    input  wire logic basic_jabber_in,
    input  wire logic basic_remote_fault_in,
    input  wire logic basic_link_in,
    input  wire logic rx10_active_in,
    input  wire logic polarity_swapped_in,
    input  wire logic rx10_valid_data_in,
    input  wire logic rx10_idle_in,
    input  wire logic rx10_link_fail_in,
    output logic      rx_error_out,
    output logic      halt_indicate_out,
    output logic      jabber_check_enable_out,
    output logic      polarity_correct_out,
    output logic      sqe_test_enable_out,
    output logic      link10_pass_out
);
    import phy_mgmt_pkg::*;

    localparam int JAB_W = $clog2(RX_JABBER_CYCLES + 1);
    localparam logic [JAB_W-1:0] JAB_MAX  = JAB_W'(RX_JABBER_CYCLES);
    localparam logic [JAB_W-1:0] JAB_LAST = JAB_W'(RX_JABBER_CYCLES - 1);

    typedef struct packed {
        logic [15:0]           rdata;
        logic                  prev_idle;
        logic [JAB_W-1:0]      jab_cnt;
        logic                  rx_err;
        logic                  halt_ind;
        logic                  sig_det;
        logic                  an_cmp;
        logic                  jab;
        logic                  rf;
        logic                  link;
        logic                  pol_rev;
        logic                  jab_chk;
        logic                  pol_fix;
        logic                  sqe_en;
        logic                  l10_pass;
        link10_state_t         l10;
        logic [OPS_CTRL_W-1:0] ctrl;
    } rg_state_t;

    rg_state_t     s;
    rg_state_t     next_s;
    logic [LH_N-1:0] ev;
    logic [LH_N-1:0] clr;
    logic [LH_N-1:0] lh;
    logic [15:0]   st_word;
    logic [15:0]   ops_word;
    logic          sym_ok;

    mgmt_access_if acc ();

    // ==========================================================
    // Management serial link
    mgmt_serial_port #(
        .PHY_ADDR (PHY_ADDR)
    ) u_port (
        .clk_in      (clk_in),
        .nrst_in     (nrst_in),
        .mdc_in      (mdc_in),
        .mdio_in     (mdio_in),
        .mdio_out    (mdio_out),
        .mdio_oe_out (mdio_oe_out),
        .acc         (acc)
    );

    // ==========================================================
    // Latching-high flags
    phy_latch_bits #(
        .N (LH_N)
    ) u_lh (
        .clk_in   (clk_in),
        .nrst_in  (nrst_in),
        .event_in (ev),
        .clear_in (clr),
        .bits_out (lh)
    );

    assign acc.rdata = s.rdata;

    // ==========================================================
    // Event detection, register access, 10M control
    always_comb begin
        next_s = s;
        clr    = '0;
        // Events other than receive jabber only qualified at 100 Mb/s
        sym_ok = speed_100_in & rx_in_packet_in & rx_symbol_strobe_in;
        ev          = '0;
        ev[LH_PLL]  = speed_100_in & pll_lock_fail_in;
        ev[LH_FC]   = speed_100_in & false_carrier_in;
        ev[LH_INV]  = sym_ok & rx_symbol_invalid_in;
        ev[LH_HALT] = sym_ok & rx_symbol_halt_in;
        ev[LH_PEND] = sym_ok & rx_symbol_idle_in & s.prev_idle;
        ev[LH_RJAB] = rx10_active_in & (s.jab_cnt == JAB_LAST);

        if (!rx_in_packet_in) begin
            next_s.prev_idle = 1'b0;
        end else if (rx_symbol_strobe_in) begin
            next_s.prev_idle = rx_symbol_idle_in;
        end

        // Counter saturates so one long burst flags only once
        if (!rx10_active_in) begin
            next_s.jab_cnt = '0;
        end else if (s.jab_cnt != JAB_MAX) begin
            next_s.jab_cnt = s.jab_cnt + JAB_W'(1);
        end

        next_s.rx_err   = sym_ok & rx_symbol_invalid_in;
        next_s.halt_ind = sym_ok & rx_symbol_halt_in;
        next_s.sig_det  = speed_100_in & signal_detect_in;
        next_s.an_cmp   = an_enable_in & an_done_in;
        next_s.jab      = basic_jabber_in;
        next_s.rf       = basic_remote_fault_in;
        next_s.link     = basic_link_in;
        next_s.pol_rev  = polarity_swapped_in;

        st_word          = '0;
        st_word[ST_PLL]  = lh[LH_PLL];
        st_word[ST_FC]   = lh[LH_FC];
        st_word[ST_INV]  = lh[LH_INV];
        st_word[ST_HALT] = lh[LH_HALT];
        st_word[ST_PEND] = lh[LH_PEND];
        st_word[ST_ANC]  = s.an_cmp;
        st_word[ST_SIG]  = s.sig_det;
        st_word[ST_JAB]  = s.jab;
        st_word[ST_RF]   = s.rf;
        st_word[ST_LINK] = s.link;
        ops_word = {lh[LH_RJAB], s.pol_rev, s.ctrl};

        if (acc.rd) begin
            unique case (acc.addr)
                REG_EXT_STATUS: begin
                    next_s.rdata = st_word;
                    clr          = LH_STATUS_SET;
                end
                REG_TENBASE_OPS: begin
                    next_s.rdata = ops_word;
                    clr[LH_RJAB] = 1'b1;
                end
                default: begin
                    next_s.rdata = '0;
                end
            endcase
        end
        // Reserved bits kept as written; host supplies defaults
        if (acc.wr && acc.addr == REG_TENBASE_OPS) begin
            next_s.ctrl = acc.wdata[OPS_CTRL_W-1:0];
        end

        next_s.jab_chk = ~s.ctrl[OPS_JAB_INH];
        next_s.pol_fix = polarity_swapped_in & ~s.ctrl[OPS_APOL_INH];
        // Stored inhibit bit untouched by duplex/repeater override
        next_s.sqe_en  = ~s.ctrl[OPS_SQE_INH]
                       & ~full_duplex_in & ~repeater_mode_in;

        // 10M link integrity
        if (s.ctrl[OPS_LINK_INH]) begin
            next_s.l10 = LINK_PASS;
        end else begin
            unique case (s.l10)
                LINK_FAIL: begin
                    if (rx10_valid_data_in) begin
                        next_s.l10 = s.ctrl[OPS_SQ_INH] ? LINK_CHECK : LINK_PASS;
                    end
                end
                LINK_CHECK: begin
                    if (rx10_link_fail_in) begin
                        next_s.l10 = LINK_FAIL;
                    end else if (rx10_idle_in) begin
                        next_s.l10 = LINK_PASS;
                    end
                end
                LINK_PASS: begin
                    if (rx10_link_fail_in) next_s.l10 = LINK_FAIL;
                end
                default: begin
                    next_s.l10 = LINK_FAIL;
                end
            endcase
        end
        next_s.l10_pass = (s.l10 == LINK_PASS);
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s <= '{l10: LINK_FAIL, ctrl: OPS_CTRL_RESET, default: '0};
        end else begin
            s <= next_s;
        end
    end

    assign rx_error_out            = s.rx_err;
    assign halt_indicate_out       = s.halt_ind;
    assign jabber_check_enable_out = s.jab_chk;
    assign polarity_correct_out    = s.pol_fix;
    assign sqe_test_enable_out     = s.sqe_en;
    assign link10_pass_out         = s.l10_pass;

    // ==========================================================
    // Checks
    property p_pll_latch;
        @(posedge clk_in) disable iff (!nrst_in)
        speed_100_in && pll_lock_fail_in |=> lh[LH_PLL];
    endproperty
    a_pll_latch: assert property (p_pll_latch)
        else $error("PLL lock error not latched");

    property p_fc_latch;
        @(posedge clk_in) disable iff (!nrst_in)
        speed_100_in && false_carrier_in |=> lh[LH_FC] && st_word[ST_FC];
    endproperty
    a_fc_latch: assert property (p_fc_latch)
        else $error("False carrier not latched");

    property p_rxer;
        @(posedge clk_in) disable iff (!nrst_in)
        sym_ok && rx_symbol_invalid_in |=> rx_error_out && lh[LH_INV];
    endproperty
    a_rxer: assert property (p_rxer)
        else $error("Invalid symbol missed RXER or flag");

    property p_pend;
        @(posedge clk_in) disable iff (!nrst_in)
        (sym_ok && rx_symbol_idle_in) ##1 (!rx_symbol_strobe_in && rx_in_packet_in)
        ##1 (sym_ok && rx_symbol_idle_in) |=> lh[LH_PEND];
    endproperty
    a_pend: assert property (p_pend)
        else $error("Premature end not latched");

    property p_an;
        @(posedge clk_in) disable iff (!nrst_in)
        !an_enable_in |=> !st_word[ST_ANC];
    endproperty
    a_an: assert property (p_an)
        else $error("Negotiation complete while disabled");

    property p_rd_clear;
        @(posedge clk_in) disable iff (!nrst_in)
        acc.rd && acc.addr == REG_EXT_STATUS && !ev[LH_HALT] |=> !lh[LH_HALT];
    endproperty
    a_rd_clear: assert property (p_rd_clear)
        else $error("Halt flag not cleared by read");

    property p_sqe_off;
        @(posedge clk_in) disable iff (!nrst_in)
        full_duplex_in || repeater_mode_in |=> !sqe_test_enable_out && $stable(s.ctrl[OPS_SQE_INH]) || $past(acc.wr);
    endproperty
    a_sqe_off: assert property (p_sqe_off)
        else $error("SQE test active in full duplex or repeater");

    property p_link_force;
        @(posedge clk_in) disable iff (!nrst_in)
        s.ctrl[OPS_LINK_INH] && $past(s.ctrl[OPS_LINK_INH]) && $past(s.ctrl[OPS_LINK_INH], 2)
        |-> link10_pass_out;
    endproperty
    a_link_force: assert property (p_link_force)
        else $error("Link not forced to pass");
endmodule : phy_rx_status_and_tenbase_ops_regs
`default_nettype wire

// ==== dv/mgmt_station_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module mgmt_station_model
    import phy_mgmt_pkg::*;
#(
    parameter logic [4:0] PHY_ADDR = 5'h01
) (
    input  wire logic clk_in,
    input  wire logic dev_data_in,
    input  wire logic dev_oe_in,
    output logic      mdc_out,
    output logic      line_out
);
    logic host_drv = 1'h1;
    logic host_bit = 1'h1;

    initial mdc_out = 1'h0;

    // Pulled-up line: with both ends released it reads high
    assign line_out = host_drv ? host_bit : (dev_oe_in ? dev_data_in : 1'h1);

    // ==========================================================
    // One whole frame; clock halves of 3 cycles keep the 2-cycle minimum
    task automatic xfer(input logic [1:0] op, input logic [4:0] ra,
                        input logic [15:0] wd, output logic [15:0] rd);
        logic [63:0] bits;
        bits = {32'hffffffff, 2'h1, op, PHY_ADDR, ra, 2'h2, wd};
        rd = 16'h0000;
        for (int i = 63; i >= 0; i--) begin
            host_drv <= !(op == OP_READ && i < 18);
            host_bit <= bits[i];
            repeat (3) @(posedge clk_in);
            if (i < 16) begin
                rd[i] = line_out;
            end
            mdc_out <= 1'h1;
            repeat (3) @(posedge clk_in);
            mdc_out <= 1'h0;
        end
        host_drv <= 1'h1;
        host_bit <= 1'h1;
        // Let an edge pass so a following frame never reassigns in this step
        @(posedge clk_in);
    endtask : xfer
endmodule : mgmt_station_model
`default_nettype wire

// ==== dv/phy_rx_status_and_tenbase_ops_regs_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module phy_rx_status_and_tenbase_ops_regs_tb;
    import phy_mgmt_pkg::*;
    logic clk_in = 1'h0;
    logic nrst_in = 1'h0;
    logic mdc_in, mdio_in, mdio_out, mdio_oe_out, rx_error_out, halt_indicate_out;
    logic jabber_check_enable_out, polarity_correct_out, sqe_test_enable_out, link10_pass_out;
    logic speed_100_in = 1'h0, full_duplex_in = 1'h0, repeater_mode_in = 1'h0;
    logic pll_lock_fail_in = 1'h0, false_carrier_in = 1'h0, rx_in_packet_in = 1'h0;
    logic rx_symbol_strobe_in = 1'h0, rx_symbol_invalid_in = 1'h0, rx_symbol_halt_in = 1'h0;
    logic rx_symbol_idle_in = 1'h0, an_enable_in = 1'h0, an_done_in = 1'h0;
    logic signal_detect_in = 1'h0, basic_jabber_in = 1'h0, basic_remote_fault_in = 1'h0;
    logic basic_link_in = 1'h0, rx10_active_in = 1'h0, polarity_swapped_in = 1'h0;
    logic rx10_valid_data_in = 1'h0, rx10_idle_in = 1'h0, rx10_link_fail_in = 1'h0;
    int          miscompares = 0;
    int          n_checks = 0;
    logic [15:0] d;

    always #25 clk_in = ~clk_in;

    // Short receive jabber span keeps the run brief
    phy_rx_status_and_tenbase_ops_regs #(.RX_JABBER_CYCLES(20)) dut (
        .clk_in, .nrst_in, .mdc_in, .mdio_in, .mdio_out, .mdio_oe_out, .speed_100_in,
        .full_duplex_in, .repeater_mode_in, .pll_lock_fail_in, .false_carrier_in,
        .rx_in_packet_in, .rx_symbol_strobe_in, .rx_symbol_invalid_in, .rx_symbol_halt_in,
        .rx_symbol_idle_in, .an_enable_in, .an_done_in, .signal_detect_in, .basic_jabber_in,
        .basic_remote_fault_in, .basic_link_in, .rx10_active_in, .polarity_swapped_in,
        .rx10_valid_data_in, .rx10_idle_in, .rx10_link_fail_in, .rx_error_out,
        .halt_indicate_out, .jabber_check_enable_out, .polarity_correct_out,
        .sqe_test_enable_out, .link10_pass_out);

    mgmt_station_model sta (.clk_in(clk_in), .dev_data_in(mdio_out), .dev_oe_in(mdio_oe_out),
                            .mdc_out(mdc_in), .line_out(mdio_in));

    // ==========================================================
    // Helpers
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
    endtask : cyc

    task automatic rchk(input logic [4:0] a, input logic [15:0] e);
        sta.xfer(OP_READ, a, 16'h0000, d);
        chk("register", e, d);
    endtask : rchk

    task automatic wr(input logic [15:0] v);
        sta.xfer(OP_WRITE, REG_TENBASE_OPS, v, d);
        cyc(2);
    endtask : wr

    task automatic outs(input logic jab, input logic pol, input logic sqe, input logic lnk);
        @(posedge clk_in);
        @(negedge clk_in);
        chk("jabber_check_enable", jab, jabber_check_enable_out);
        chk("polarity_correct", pol, polarity_correct_out);
        chk("sqe_test_enable", sqe, sqe_test_enable_out);
        chk("link10_pass", lnk, link10_pass_out);
        @(posedge clk_in);
    endtask : outs

    task automatic sym(input logic inv, input logic hlt, input logic idl);
        rx_symbol_strobe_in <= 1'h1;
        rx_symbol_invalid_in <= inv;
        rx_symbol_halt_in <= hlt;
        rx_symbol_idle_in <= idl;
        @(posedge clk_in);
        rx_symbol_strobe_in <= 1'h0;
        @(negedge clk_in);
        chk("rx_error", inv, rx_error_out);
        chk("halt_indicate", hlt, halt_indicate_out);
        @(posedge clk_in);
    endtask : sym

    task automatic evts(input logic spd);
        @(posedge clk_in);
        speed_100_in <= spd;
        pll_lock_fail_in <= 1'h1;
        false_carrier_in <= 1'h1;
        @(posedge clk_in);
        pll_lock_fail_in <= 1'h0;
        false_carrier_in <= 1'h0;
        cyc(2);
    endtask : evts

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        outs(1'h1, 1'h0, 1'h1, 1'h0);
        rchk(REG_TENBASE_OPS, 16'h0010);
        rchk(REG_EXT_STATUS, 16'h0000);
        rchk(5'h05, 16'h0000);
    endtask : t_reset

    task automatic t_errors();
        @(posedge clk_in);
        speed_100_in <= 1'h1;
        rx_in_packet_in <= 1'h1;
        sym(1'h1, 1'h0, 1'h0);
        sym(1'h0, 1'h1, 1'h0);
        sym(1'h0, 1'h0, 1'h1);
        sym(1'h0, 1'h0, 1'h1);
        rx_in_packet_in <= 1'h0;
        evts(1'h1);
        rchk(REG_EXT_STATUS, 16'h03e0);
        rchk(REG_EXT_STATUS, 16'h0000);
        evts(1'h0);
        rchk(REG_EXT_STATUS, 16'h0000);
    endtask : t_errors

    task automatic t_mirrors();
        speed_100_in <= 1'h1;
        an_enable_in <= 1'h1;
        an_done_in <= 1'h1;
        signal_detect_in <= 1'h1;
        basic_jabber_in <= 1'h1;
        basic_remote_fault_in <= 1'h1;
        basic_link_in <= 1'h1;
        rchk(REG_EXT_STATUS, 16'h001f);
        an_enable_in <= 1'h0;
        speed_100_in <= 1'h0;
        basic_link_in <= 1'h0;
        rchk(REG_EXT_STATUS, 16'h0006);
    endtask : t_mirrors

    task automatic t_ops();
        polarity_swapped_in <= 1'h1;
        wr(16'h003f);
        outs(1'h0, 1'h0, 1'h0, 1'h1);
        rchk(REG_TENBASE_OPS, 16'h403f);
        wr(16'h0010);
        rx10_link_fail_in <= 1'h1;
        cyc(2);
        rx10_link_fail_in <= 1'h0;
        cyc(2);
        outs(1'h1, 1'h1, 1'h1, 1'h0);
        full_duplex_in <= 1'h1;
        outs(1'h1, 1'h1, 1'h0, 1'h0);
        full_duplex_in <= 1'h0;
        repeater_mode_in <= 1'h1;
        outs(1'h1, 1'h1, 1'h0, 1'h0);
        rchk(REG_TENBASE_OPS, 16'h4010);
        repeater_mode_in <= 1'h0;
        polarity_swapped_in <= 1'h0;
    endtask : t_ops

    task automatic t_link();
        rx10_valid_data_in <= 1'h1;
        cyc(3);
        rx10_valid_data_in <= 1'h0;
        cyc(2);
        outs(1'h1, 1'h0, 1'h1, 1'h1);
        wr(16'h0011);
        rx10_link_fail_in <= 1'h1;
        cyc(2);
        rx10_link_fail_in <= 1'h0;
        rx10_valid_data_in <= 1'h1;
        cyc(3);
        rx10_valid_data_in <= 1'h0;
        cyc(2);
        outs(1'h1, 1'h0, 1'h1, 1'h0);
        rx10_idle_in <= 1'h1;
        cyc(3);
        rx10_idle_in <= 1'h0;
        cyc(2);
        outs(1'h1, 1'h0, 1'h1, 1'h1);
    endtask : t_link

    task automatic t_rjab();
        rx10_active_in <= 1'h1;
        cyc(25);
        rx10_active_in <= 1'h0;
        cyc(2);
        rchk(REG_TENBASE_OPS, 16'h8011);
        rchk(REG_TENBASE_OPS, 16'h0011);
    endtask : t_rjab

    task automatic end_of_test();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (20) @(posedge clk_in);
        nrst_in <= 1'h1;
        cyc(2);
        t_reset();
        t_errors();
        t_mirrors();
        t_ops();
        t_link();
        t_rjab();
        end_of_test();
    end

    // About 15 frames of 384 cycles each; 40000 cycles is ample
    initial begin
        repeat (40000) @(posedge clk_in);
        miscompares++;
        end_of_test();
    end
endmodule : phy_rx_status_and_tenbase_ops_regs_tb
`default_nettype wire
